// ===== hw/eia_pkg.sv
package eia_pkg;

	localparam int          EIA_DEPTH      = 64;
	localparam int          EIA_AW         = 6;
	localparam int          EIA_PTR_W      = 7;
	localparam int          EIA_DW         = 8;
	localparam int          EIA_KEY_N      = 3;
	localparam logic [7:0]  EIA_KEY0       = 8'hC9;
	localparam logic [7:0]  EIA_KEY1       = 8'h3A;
	localparam logic [7:0]  EIA_KEY2       = 8'hD3;
	localparam logic [6:0]  EIA_PTR_RST    = 7'h00;
	localparam logic [7:0]  EIA_DATA_RST   = 8'h00;
	localparam logic        EIA_LOCK_RST   = 1'b1;
	// Programming time of one array byte
	localparam int          EIA_CLK_MHZ    = 10;
	localparam int          EIA_PROG_US    = 2;
	localparam int          EIA_PROG_CYC   = EIA_PROG_US * EIA_CLK_MHZ;

	typedef enum logic [2:0] {
		EIA_OP_NONE,
		EIA_OP_ADDR_READ,
		EIA_OP_ADDR_WRITE,
		EIA_OP_DATA_READ,
		EIA_OP_DATA_WRITE,
		EIA_OP_ARRAY_FETCH,
		EIA_OP_ARRAY_PROGRAM,
		EIA_OP_KEY_LOAD
	} eia_op_type;

	typedef struct packed {
		eia_op_type  op;
		logic [7:0]  accumulator;
	} eia_instr_type;

	typedef struct packed {
		logic        acc_valid;
		logic [7:0]  acc_value;
		logic        acc_unknown;
	} eia_result_type;

endpackage : eia_pkg

// ===== hw/eia_key_match.sv
`timescale 1ns/1ps
module eia_key_match (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_resetn,
	// Key loads
	input  wire logic       i_key_load,
	input  wire logic [7:0] i_key_value,
	// Relock after a write
	input  wire logic       i_relock,
	// Status
	output logic            o_write_locked_flag
);
	import eia_pkg::*;

	logic [1:0] stage_q;
	logic [1:0] stage_d;
	logic       locked_q;
	logic       locked_d;
	logic [7:0] expect_key;
	wire        key_hit = (i_key_value == expect_key);
	wire        restart_hit = (i_key_value == EIA_KEY0);

	assign expect_key = (stage_q == 2'h0) ? EIA_KEY0 :
	                    (stage_q == 2'h1) ? EIA_KEY1 : EIA_KEY2;

	always_comb begin
		stage_d  = stage_q;
		locked_d = locked_q;
		if (i_relock) begin
			locked_d = 1'b1;
			stage_d  = 2'h0;
		end else if (i_key_load) begin
			if (key_hit && stage_q == 2'h2) begin
				locked_d = 1'b0; // [RULE9]
				stage_d  = 2'h0;
			end else if (key_hit) begin
				stage_d = stage_q + 2'h1;
			end else begin
				// A broken sequence may itself start a new one
				stage_d = restart_hit ? 2'h1 : 2'h0; // [RULE14]
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			stage_q  <= 2'h0;
			locked_q <= EIA_LOCK_RST; // [RULE13]
		end else begin
			stage_q  <= stage_d;
			locked_q <= locked_d;
		end
	end

	assign o_write_locked_flag = locked_q;

	chk_full_key_unlocks: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE9]
		(i_key_load && !i_relock && stage_q == 2'h2 && i_key_value == EIA_KEY2)
		|=> !o_write_locked_flag)
		else $error("Third key did not unlock");

	chk_unlock_needs_key: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE9]
		($fell(o_write_locked_flag)) |-> $past(i_key_load) && $past(stage_q) == 2'h2)
		else $error("Unlock without full key");

	chk_bad_key_restart: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE14]
		(i_key_load && !i_relock && !key_hit && !restart_hit) |=> stage_q == 2'h0)
		else $error("Broken key did not restart matching");

endmodule : eia_key_match

// ===== hw/eia_eeprom_indirect_access.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Array reached only through address, data and unlock key holding registers.
// [RULE2] Array holds 64 bytes, byte chosen by the address holder.
// [RULE3] Software keeps address bit 6 at zero.
// [RULE4] Address read copies holder to accumulator; address write loads it.
// [RULE5] Data read copies data holder to accumulator; data write loads it.
// [RULE6] Array fetch loads data holder from array; accumulator then undefined.
// [RULE7] Array program writes data holder into array when unlocked.
// [RULE8] Software loads keys C9H, 3AH, D3H consecutively before each write.
// [RULE9] Writes unlock only after the full three-key sequence.
// [RULE10] Completed write sets done flag; interrupt needs enable and global enable.
// [RULE11] Software writes only in normal clock mode.
// [RULE12] Software should keep watchdog reset enabled during writes.
// [RULE13] Read-only lock bit is 1 locked, 0 unlocked, 1 after reset.
// [RULE14] Bad key restarts matching; each completed write relocks.
module eia_eeprom_indirect_access #(
	parameter int DEPTH    = eia_pkg::EIA_DEPTH,
	parameter int PROG_CYC = eia_pkg::EIA_PROG_CYC
) (
	// Clock and reset
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_resetn,
	// Instruction from the core
	input  wire eia_pkg::eia_instr_type  i_instr,
	// Answer to the core
	output eia_pkg::eia_result_type      o_result,
	output logic                         o_busy,
	// Interrupt side
	input  wire logic                    i_write_done_irq_en,
	input  wire logic                    i_global_irq_en,
	input  wire logic                    i_write_done_flag_clr,
	output logic                         o_write_done_flag,
	output logic                         o_irq_req,
	// Status
	output logic                         o_write_locked_flag
);
	import eia_pkg::*;

	typedef enum {EIA_IDLE, EIA_PROG} eia_state_type;

	logic [7:0]          array_mem [DEPTH];
	logic [EIA_PTR_W-1:0] eeprom_address_pointer_q;
	logic [7:0]          eeprom_data_holding_q;
	eia_result_type      result_q;
	eia_state_type       state_q;
	logic [15:0]         prog_cnt_q;
	logic                write_done_flag_q;
	logic                prog_done;
	logic                write_locked;

	wire [EIA_AW-1:0] array_index = eeprom_address_pointer_q[EIA_AW-1:0]; // [RULE2] [RULE3]
	wire op_addr_rd   = (i_instr.op == EIA_OP_ADDR_READ);
	wire op_addr_wr   = (i_instr.op == EIA_OP_ADDR_WRITE);
	wire op_data_rd   = (i_instr.op == EIA_OP_DATA_READ);
	wire op_data_wr   = (i_instr.op == EIA_OP_DATA_WRITE);
	wire op_fetch     = (i_instr.op == EIA_OP_ARRAY_FETCH);
	wire op_program   = (i_instr.op == EIA_OP_ARRAY_PROGRAM);
	wire op_key       = (i_instr.op == EIA_OP_KEY_LOAD);
	wire idle         = (state_q == EIA_IDLE);
	// Holding registers stay frozen while a byte is programmed
	wire take         = idle;
	wire prog_start   = take && op_program && !write_locked; // [RULE7] [RULE9]

	assign prog_done = (state_q == EIA_PROG) && (prog_cnt_q == 16'(PROG_CYC - 1));

	eia_key_match u_key (
		.i_clk_sys           (i_clk_sys),
		.i_resetn            (i_resetn),
		.i_key_load          (take && op_key), // [RULE1]
		.i_key_value         (i_instr.accumulator),
		.i_relock            (prog_done), // [RULE14]
		.o_write_locked_flag (write_locked)
	);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			eeprom_address_pointer_q <= EIA_PTR_RST;
			eeprom_data_holding_q    <= EIA_DATA_RST;
		end else if (take) begin
			if (op_addr_wr)
				eeprom_address_pointer_q <= i_instr.accumulator[EIA_PTR_W-1:0]; // [RULE4]
			if (op_data_wr)
				eeprom_data_holding_q <= i_instr.accumulator; // [RULE5]
			else if (op_fetch)
				eeprom_data_holding_q <= array_mem[array_index]; // [RULE6]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (prog_done)
			array_mem[array_index] <= eeprom_data_holding_q; // [RULE7]
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			result_q <= '0;
		end else begin
			result_q.acc_valid   <= take && (op_addr_rd || op_data_rd || op_fetch);
			result_q.acc_unknown <= take && op_fetch; // [RULE6]
			if (take && op_addr_rd)
				result_q.acc_value <= {1'b0, eeprom_address_pointer_q}; // [RULE4]
			else if (take && op_data_rd)
				result_q.acc_value <= eeprom_data_holding_q; // [RULE5]
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q    <= EIA_IDLE;
			prog_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				EIA_IDLE: begin
					prog_cnt_q <= 16'h0000;
					if (prog_start)
						state_q <= EIA_PROG;
				end
				EIA_PROG: begin
					prog_cnt_q <= prog_cnt_q + 16'h0001;
					if (prog_done)
						state_q <= EIA_IDLE;
				end
				default: state_q <= EIA_IDLE;
			endcase
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			write_done_flag_q <= 1'b0;
		else if (prog_done)
			write_done_flag_q <= 1'b1; // [RULE10]
		else if (i_write_done_flag_clr)
			write_done_flag_q <= 1'b0;
	end

	assign o_result            = result_q;
	assign o_busy              = !idle;
	assign o_write_done_flag   = write_done_flag_q;
	assign o_irq_req           = write_done_flag_q && i_write_done_irq_en && i_global_irq_en; // [RULE10]
	assign o_write_locked_flag = write_locked; // [RULE13]

	sequence s_prog_begin;
		prog_start;
	endsequence

	sequence s_prog_end;
		##PROG_CYC $rose(o_write_done_flag) || (o_write_done_flag && $past(prog_done));
	endsequence

	// Done flag must follow exactly PROG_CYC busy cycles after the start
	chk_write_done_time: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE10]
		s_prog_begin |-> ##1 o_busy ##0 s_prog_end)
		else $error("Write done not raised on time");

	chk_locked_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE7]
		(idle && op_program && write_locked) |=> !o_busy)
		else $error("Locked write was started");

	chk_relock_after: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE14]
		prog_done |=> o_write_locked_flag && !o_busy)
		else $error("Write did not relock");

	// Covers a load and read with one cycle between; back-to-back pairs are not checked
	sequence s_addr_load_read;
		(take && op_addr_wr) ##1 !op_addr_wr ##1 (idle && op_addr_rd);
	endsequence

	sequence s_data_load_read;
		(take && op_data_wr) ##1 !(op_data_wr || op_fetch) ##1 (idle && op_data_rd);
	endsequence

	// Bit 7 of the accumulator is not stored, so it reads back as zero
	chk_addr_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE4]
		s_addr_load_read |=> o_result.acc_valid
		&& o_result.acc_value == {1'b0, $past(i_instr.accumulator[EIA_PTR_W-1:0], 3)})
		else $error("Address holder read back wrong");

	chk_data_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE5]
		s_data_load_read |=> o_result.acc_valid
		&& o_result.acc_value == $past(i_instr.accumulator, 3))
		else $error("Data holder read back wrong");

	chk_ptr_load: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE4]
		(take && op_addr_wr)
		|=> eeprom_address_pointer_q == $past(i_instr.accumulator[EIA_PTR_W-1:0]))
		else $error("Address holder not loaded");

	chk_fetch_unknown: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE6]
		(take && op_fetch) |=> o_result.acc_unknown
		&& eeprom_data_holding_q == array_mem[$past(array_index)])
		else $error("Array fetch wrong");

	chk_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE10]
		(prog_done && i_write_done_irq_en && i_global_irq_en)
		##1 (i_write_done_irq_en && i_global_irq_en) |-> o_irq_req)
		else $error("Interrupt not raised after write");

	chk_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE10]
		(o_write_done_flag && !i_write_done_flag_clr) |=> o_write_done_flag)
		else $error("Done flag dropped without clear");

	// A refused instruction must leave the data holder as the array expects it
	chk_busy_freezes: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE7]
		(o_busy && (op_data_wr || op_fetch)) |=> $stable(eeprom_data_holding_q))
		else $error("Data holder changed while programming");

	chk_busy_no_answer: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE7]
		o_busy |=> !o_result.acc_valid && !o_result.acc_unknown)
		else $error("Answer given while programming");

	chk_array_written: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE7]
		prog_done |=> array_mem[$past(array_index)] == $past(eeprom_data_holding_q))
		else $error("Array byte not programmed");

	chk_lock_reset: assert property (@(posedge i_clk_sys) // [RULE13]
		$rose(i_resetn) |-> o_write_locked_flag)
		else $error("Lock bit not set after reset");

endmodule : eia_eeprom_indirect_access

// ===== dv/eia_core_model.sv
`timescale 1ns/1ps
module eia_core_model (
	// Clock
	input  wire logic              i_clk_sys,
	// Instruction to the unit
	output eia_pkg::eia_instr_type o_instr
);
	import eia_pkg::*;
	initial o_instr = '{EIA_OP_NONE, 8'h00};
	// One instruction, then an idle cycle; accumulator flipped so stale data is never reused
	// Full instruction rate only; no slow clock mode is modelled
	task automatic exec(input eia_op_type op, input logic [7:0] acc);
		@(negedge i_clk_sys);
		o_instr <= '{op, acc};
		@(negedge i_clk_sys);
		o_instr <= '{EIA_OP_NONE, ~acc};
	endtask : exec
endmodule : eia_core_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
	import eia_pkg::*;
	logic           clk_sys = 1'b0;
	logic           resetn  = 1'b0;
	logic           irq_en  = 1'b0;
	logic           gen     = 1'b0;
	logic           clr     = 1'b0;
	eia_instr_type  instr;
	eia_result_type res;
	logic           busy, flag, irq, locked;
	logic [8:0]     q[$];
	logic [7:0]     mem[64];
	logic [5:0]     adr[4];
	logic [8:0]     e;
	int             bad_count = 0;
	int             tests_run = 0;
	int             seed      = 52455;
	localparam int  PROG_CYC  = 5;
	always #50 clk_sys = ~clk_sys;
	eia_core_model eia_core_model_i (.i_clk_sys(clk_sys), .o_instr(instr));
	eia_eeprom_indirect_access #(.PROG_CYC(PROG_CYC)) eia_eeprom_indirect_access_i (
		.i_clk_sys(clk_sys), .i_resetn(resetn), .i_instr(instr), .o_result(res),
		.o_busy(busy), .i_write_done_irq_en(irq_en), .i_global_irq_en(gen),
		.i_write_done_flag_clr(clr), .o_write_done_flag(flag), .o_irq_req(irq),
		.o_write_locked_flag(locked));
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic ex(input eia_op_type op, input logic [7:0] acc);
		eia_core_model_i.exec(op, acc);
	endtask : ex
	task automatic keys();
		ex(EIA_OP_KEY_LOAD, EIA_KEY0);
		ex(EIA_OP_KEY_LOAD, EIA_KEY1);
		ex(EIA_OP_KEY_LOAD, EIA_KEY2);
	endtask : keys
	task automatic prog(input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		ex(EIA_OP_ADDR_WRITE, {2'b00, a});
		ex(EIA_OP_DATA_WRITE, d);
		keys();
		chk(locked === 1'b0, "still locked");
		ex(EIA_OP_ARRAY_PROGRAM, 8'h00);
		chk(busy === 1'b1, "program not started");
		// Must be ignored while busy
		ex(EIA_OP_DATA_WRITE, ~d);
		while (busy !== 1'b0) begin
			@(negedge clk_sys);
			n++;
			// Stands in for the watchdog a stalled write would need
			if (n > 50) begin
				chk(1'b0, "busy stuck");
				test_done();
			end
		end
		// Two of the busy cycles pass inside the two calls above
		chk(n == PROG_CYC - 2, "program length");
		chk(flag === 1'b1 && locked === 1'b1, "done flag or relock");
		q.push_back({1'b0, d});
		ex(EIA_OP_DATA_READ, 8'h00);
	endtask : prog
	// Scoreboard: oldest note against each answer
	always @(negedge clk_sys) begin
		if (res.acc_unknown === 1'b1 || res.acc_valid === 1'b1) begin
			e = (q.size() > 0) ? q.pop_front() : 9'h1FF;
			if (e[8])
				chk(res.acc_unknown === 1'b1, "fetch not flagged");
			else
				chk(res.acc_valid === 1'b1 && res.acc_value === e[7:0], "read value");
		end
	end
	initial begin
		logic [7:0] d;
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		chk(locked === 1'b1 && busy === 1'b0 && flag === 1'b0, "reset state");
		d = $random(seed);
		ex(EIA_OP_ADDR_WRITE, {d[7], 1'b0, d[5:0]});
		q.push_back({3'b000, d[5:0]});
		ex(EIA_OP_ADDR_READ, 8'h00);
		$display("address holder test done");
		ex(EIA_OP_ARRAY_PROGRAM, 8'h00);
		chk(busy === 1'b0 && flag === 1'b0, "locked write ran");
		ex(EIA_OP_KEY_LOAD, EIA_KEY0);
		ex(EIA_OP_KEY_LOAD, EIA_KEY1);
		ex(EIA_OP_KEY_LOAD, 8'h00);
		ex(EIA_OP_KEY_LOAD, EIA_KEY2);
		chk(locked === 1'b1, "broken key unlocked");
		$display("lock test done");
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			adr[i] = (i == 0) ? 6'h00 : (i == 3) ? 6'h3F : d[5:0];
			d = $random(seed);
			mem[adr[i]] = d;
			irq_en = i[0];
			gen = i[1];
			prog(adr[i], d);
			chk(irq === (i[0] & i[1]), "irq request");
			clr = 1'b1;
			@(negedge clk_sys);
			clr = 1'b0;
			chk(flag === 1'b0 && irq === 1'b0, "flag not cleared");
		end
		$display("program test done");
		for (int i = 0; i < 4; i++) begin
			ex(EIA_OP_ADDR_WRITE, {2'b00, adr[i]});
			q.push_back(9'h100);
			ex(EIA_OP_ARRAY_FETCH, 8'h00);
			q.push_back({1'b0, mem[adr[i]]});
			ex(EIA_OP_DATA_READ, 8'h00);
		end
		$display("fetch test done");
		d = $random(seed);
		ex(EIA_OP_DATA_WRITE, d);
		q.push_back({1'b0, d});
		ex(EIA_OP_DATA_READ, 8'h00);
		keys();
		chk(locked === 1'b0, "key did not unlock");
		// Mid-run reset must bring the lock back
		resetn = 1'b0;
		@(negedge clk_sys);
		resetn = 1'b1;
		chk(locked === 1'b1 && busy === 1'b0 && flag === 1'b0, "reset lost lock");
		$display("reset test done");
		repeat (3) @(negedge clk_sys);
		chk(q.size() == 0, "answers missing");
		test_done();
	end
endmodule : tb
